// ---- blit_param_pkg.sv ----
// Purpose: Shared constants and carriers for the 2D parameter register set
// Assumes: Byte addresses within the engine register window, 32-bit words
// Notes:   Three drawing sets, each with its own copy of the parameters
package blit_param_pkg;

  // Register byte offsets
  localparam logic [15:0] OFS_BLIT_PITCH      = 16'ha4e4;
  localparam logic [15:0] OFS_BLIT_PAT_LOW    = 16'ha4e8;
  localparam logic [15:0] OFS_BLIT_PAT_HIGH   = 16'ha4ec;
  localparam logic [15:0] OFS_BLIT_PAT_BACK   = 16'ha4f0;
  localparam logic [15:0] OFS_BLIT_PAT_FORE   = 16'ha4f4;
  localparam logic [15:0] OFS_BLIT_SRC_FORE   = 16'ha4fc;
  localparam logic [15:0] OFS_BLIT_COMMAND    = 16'ha500;
  localparam logic [15:0] OFS_BLIT_TARGET_POS = 16'ha50c;
  localparam logic [15:0] OFS_LINE_PITCH      = 16'ha8e4;
  localparam logic [15:0] OFS_LINE_PAT_FORE   = 16'ha8f4;
  localparam logic [15:0] OFS_LINE_COMMAND    = 16'ha900;
  localparam logic [15:0] OFS_LINE_COUNT      = 16'ha97c;
  localparam logic [15:0] OFS_POLY_PITCH      = 16'hace4;
  localparam logic [15:0] OFS_POLY_PAT_LOW    = 16'hace8;
  localparam logic [15:0] OFS_POLY_PAT_HIGH   = 16'hacec;
  localparam logic [15:0] OFS_POLY_PAT_BACK   = 16'hacf0;
  localparam logic [15:0] OFS_POLY_PAT_FORE   = 16'hacf4;
  localparam logic [15:0] OFS_POLY_COMMAND    = 16'had00;
  localparam logic [15:0] OFS_POLY_COUNT      = 16'had7c;

  // Writable masks (reserved bits and aligned stride low bits zero)
  localparam logic [31:0] MASK_PITCH   = 32'h0ff8_0ff8;
  localparam logic [31:0] MASK_COLOR   = 32'h00ff_ffff;
  localparam logic [31:0] MASK_COMMAND = 32'hffff_3fff;
  localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;

  // Command field positions
  localparam int CMD_AUTO_BIT   = 0;
  localparam int CMD_CLIP_BIT   = 1;
  localparam int CMD_DEPTH_LO   = 2;
  localparam int CMD_MONO_SRC   = 6;
  localparam int CMD_MONO_PAT   = 8;
  localparam int CMD_TRANSP     = 9;
  localparam int CMD_OPCODE_LO  = 27;

  // Target color depth codes
  localparam logic [2:0] DEPTH_8  = 3'h0;
  localparam logic [2:0] DEPTH_16 = 3'h1;
  localparam logic [2:0] DEPTH_24 = 3'h2;

  // Drawing opcodes
  localparam logic [3:0] OP_BLIT   = 4'h0;
  localparam logic [3:0] OP_RECT   = 4'h2;
  localparam logic [3:0] OP_LINE   = 4'h3;
  localparam logic [3:0] OP_POLY   = 4'h5;
  localparam logic [3:0] OP_NOOP   = 4'hf;

  // Drawing set selector
  typedef enum logic [1:0] {SET_BLIT, SET_LINE, SET_POLY, SET_NONE} draw_set_t;

  // One drawing set's parameters
  typedef struct packed {
    logic [31:0] pitch;
    logic [31:0] pat_low;
    logic [31:0] pat_high;
    logic [31:0] pat_back;
    logic [31:0] pat_fore;
    logic [31:0] src_fore;
    logic [31:0] command;
  } param_set_t;

  // Launch event to the engine
  typedef struct packed {
    logic        valid;
    logic [1:0]  set;
    logic [31:0] command;
  } launch_t;

  // Per-pixel query from the pixel pipeline
  typedef struct packed {
    logic [1:0]  set;
    logic [2:0]  row;
    logic [2:0]  col;
    logic [23:0] pixel;
    logic        image_bit;
  } pixel_query_t;

  // Per-pixel answer
  typedef struct packed {
    logic [23:0] pattern_color;
    logic [23:0] source_color;
    logic        write_enable;
  } pixel_answer_t;

endpackage : blit_param_pkg

// ---- blit_param_registers_2d.sv ----
// Purpose: Parameter and command registers of the 2D drawing engine
// Assumes: Plain strobe register port, read data one cycle after strobe
// Notes:   Also resolves pattern and source colors for the pixel pipeline
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns

module blit_param_registers_2d
  import blit_param_pkg::*;
(
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_sys_rst,
  // Register port
  input  wire logic [15:0]   i_reg_addr,
  input  wire logic [31:0]   i_reg_wdata,
  input  wire logic          i_reg_write,
  input  wire logic          i_reg_read,
  output logic      [31:0]   o_reg_rdata,
  // Launch to the drawing engine
  output launch_t            o_launch,
  output logic               o_clip_enable,
  // Pixel pipeline query and answer
  input  wire pixel_query_t  i_pixel_query,
  output pixel_answer_t      o_pixel_answer
);

  // Whole module state
  typedef struct packed {
    param_set_t    [2:0] sets;
    logic          [31:0] rdata;
    launch_t       launch;
    logic                 clip;
    pixel_answer_t answer;
  } state_t;

  state_t state_q;        // Registered state
  state_t state_d;        // Next state

  // Color limited to the defined bytes for a depth
  function automatic logic [23:0] depth_color(input logic [31:0] c, input logic [2:0] d);
    unique case (d)
      DEPTH_8:  depth_color = {16'h0000, c[7:0]};
      DEPTH_16: depth_color = {8'h00, c[15:0]};
      default:  depth_color = c[23:0];
    endcase
  endfunction

  // Register decode: which set and which slot, slot 7 is the launch trigger
  function automatic logic [4:0] decode(input logic [15:0] a);
    unique case (a)
      OFS_BLIT_PITCH:      decode = {2'h0, 3'h0};
      OFS_BLIT_PAT_LOW:    decode = {2'h0, 3'h1};
      OFS_BLIT_PAT_HIGH:   decode = {2'h0, 3'h2};
      OFS_BLIT_PAT_BACK:   decode = {2'h0, 3'h3};
      OFS_BLIT_PAT_FORE:   decode = {2'h0, 3'h4};
      OFS_BLIT_SRC_FORE:   decode = {2'h0, 3'h5};
      OFS_BLIT_COMMAND:    decode = {2'h0, 3'h6};
      OFS_BLIT_TARGET_POS: decode = {2'h0, 3'h7};
      OFS_LINE_PITCH:      decode = {2'h1, 3'h0};
      OFS_LINE_PAT_FORE:   decode = {2'h1, 3'h4};
      OFS_LINE_COMMAND:    decode = {2'h1, 3'h6};
      OFS_LINE_COUNT:      decode = {2'h1, 3'h7};
      OFS_POLY_PITCH:      decode = {2'h2, 3'h0};
      OFS_POLY_PAT_LOW:    decode = {2'h2, 3'h1};
      OFS_POLY_PAT_HIGH:   decode = {2'h2, 3'h2};
      OFS_POLY_PAT_BACK:   decode = {2'h2, 3'h3};
      OFS_POLY_PAT_FORE:   decode = {2'h2, 3'h4};
      OFS_POLY_COMMAND:    decode = {2'h2, 3'h6};
      OFS_POLY_COUNT:      decode = {2'h2, 3'h7};
      default:             decode = {2'h3, 3'h0};
    endcase
  endfunction

  // Slot write mask so reserved bits stay zero
  function automatic logic [31:0] slot_mask(input logic [2:0] s);
    unique case (s)
      3'h0:      slot_mask = MASK_PITCH;
      3'h1, 3'h2: slot_mask = 32'hffff_ffff;
      3'h6:      slot_mask = MASK_COMMAND;
      3'h7:      slot_mask = 32'h0000_0000;
      default:   slot_mask = MASK_COLOR;
    endcase
  endfunction

  logic [4:0]  wr_dec;     // Decoded write address
  logic [4:0]  rd_dec;     // Decoded read address
  param_set_t  qs;         // Set addressed by the pixel query
  logic [63:0] pattern;    // Full 8x8 mono pattern
  logic        pat_bit;    // Current pattern bit
  logic [2:0]  depth;      // Target color depth of the queried set
  logic [3:0]  opcode;     // Opcode of the queried set
  logic [23:0] pixel_cut;  // Incoming pixel at target depth
  logic [23:0] key_cut;    // Transparency key at target depth

  // Next-state logic: register writes, reads, launches and pixel answers
  always_comb begin
    state_d = state_q;
    wr_dec  = decode(i_reg_addr);
    rd_dec  = wr_dec;
    state_d.launch.valid = 1'b0;
    state_d.rdata = 32'h0000_0000;
    // Register write into the addressed set, separate copies per set
    if (i_reg_write && wr_dec[4:3] != 2'h3) begin
      unique case (wr_dec[2:0])
        3'h0: state_d.sets[wr_dec[4:3]].pitch    = i_reg_wdata & slot_mask(3'h0);
        3'h1: state_d.sets[wr_dec[4:3]].pat_low  = i_reg_wdata;
        3'h2: state_d.sets[wr_dec[4:3]].pat_high = i_reg_wdata;
        3'h3: state_d.sets[wr_dec[4:3]].pat_back = i_reg_wdata & slot_mask(3'h3);
        3'h4: state_d.sets[wr_dec[4:3]].pat_fore = i_reg_wdata & slot_mask(3'h4);
        3'h5: state_d.sets[wr_dec[4:3]].src_fore = i_reg_wdata & slot_mask(3'h5);
        3'h6: state_d.sets[wr_dec[4:3]].command  = i_reg_wdata & slot_mask(3'h6);
        3'h7: state_d.sets[wr_dec[4:3]].command  = state_q.sets[wr_dec[4:3]].command;
      endcase
      // Immediate launch unless the auto bit is set or the command is a no-op
      if (wr_dec[2:0] == 3'h6 && !i_reg_wdata[CMD_AUTO_BIT]
          && i_reg_wdata[CMD_OPCODE_LO +: 4] != OP_NOOP) begin
        state_d.launch.valid   = 1'b1;
        state_d.launch.set     = wr_dec[4:3];
        state_d.launch.command = i_reg_wdata & MASK_COMMAND;
      end
      // Trigger register relaunches the stored command
      if (wr_dec[2:0] == 3'h7
          && state_q.sets[wr_dec[4:3]].command[CMD_AUTO_BIT]) begin
        state_d.launch.valid   = 1'b1;
        state_d.launch.set     = wr_dec[4:3];
        state_d.launch.command = state_q.sets[wr_dec[4:3]].command;
      end
    end
    // Register read, unmapped and trigger words read zero
    if (i_reg_read && rd_dec[4:3] != 2'h3) begin
      unique case (rd_dec[2:0])
        3'h0: state_d.rdata = state_q.sets[rd_dec[4:3]].pitch;
        3'h1: state_d.rdata = state_q.sets[rd_dec[4:3]].pat_low;
        3'h2: state_d.rdata = state_q.sets[rd_dec[4:3]].pat_high;
        3'h3: state_d.rdata = state_q.sets[rd_dec[4:3]].pat_back;
        3'h4: state_d.rdata = state_q.sets[rd_dec[4:3]].pat_fore;
        3'h5: state_d.rdata = state_q.sets[rd_dec[4:3]].src_fore;
        3'h6: state_d.rdata = state_q.sets[rd_dec[4:3]].command;
        3'h7: state_d.rdata = 32'h0000_0000;
      endcase
    end
    // Clip enable follows the last launched command
    if (state_d.launch.valid) begin
      state_d.clip = state_d.launch.command[CMD_CLIP_BIT];
    end
    // Pixel answer for the queried set
    qs = (i_pixel_query.set == 2'h3) ? state_q.sets[0] : state_q.sets[i_pixel_query.set];
    pattern = {qs.pat_high, qs.pat_low};
    // Line n in byte n, left pixel in the byte MSB
    pat_bit = pattern[{i_pixel_query.row, 3'h7 - i_pixel_query.col}];
    depth  = qs.command[CMD_DEPTH_LO +: 3];
    opcode = qs.command[CMD_OPCODE_LO +: 4];
    // Pattern color: fills and lines always use the foreground
    if (opcode == OP_RECT || opcode == OP_LINE || opcode == OP_POLY
        || (qs.command[CMD_MONO_PAT] && pat_bit)) begin
      state_d.answer.pattern_color = depth_color(qs.pat_fore, depth);
    end else if (qs.command[CMD_MONO_PAT]) begin
      state_d.answer.pattern_color = depth_color(qs.pat_back, depth);
    end else begin
      state_d.answer.pattern_color = 24'h000000;             // Color pattern lives elsewhere
    end
    pixel_cut = depth_color({8'h00, i_pixel_query.pixel}, depth);
    key_cut   = depth_color(qs.src_fore, depth);
    if (qs.command[CMD_MONO_SRC]) begin
      // Mono source uses the full 24-bit source color
      state_d.answer.source_color = qs.src_fore[23:0];
      state_d.answer.write_enable = i_pixel_query.image_bit
                                    || !qs.command[CMD_TRANSP];
    end else begin
      state_d.answer.source_color = i_pixel_query.pixel;
      // Key compare at every depth code except DEPTH_24; codes 3 to 7 compare the full 24-bit key
      state_d.answer.write_enable = !(qs.command[CMD_TRANSP] && depth != DEPTH_24
                                      && pixel_cut == key_cut);
    end
  end

  // State register; power-on contents are undefined, cleared here for determinism
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign o_reg_rdata    = state_q.rdata;
  assign o_launch       = state_q.launch;
  assign o_clip_enable  = state_q.clip;
  assign o_pixel_answer = state_q.answer;

  // Immediate launch one cycle after a command write with auto off
  property p_immediate_launch;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_BLIT_COMMAND && !i_reg_wdata[0]
       && i_reg_wdata[30:27] != 4'hf) |=> (o_launch.valid && o_launch.set == 2'h0);
  endproperty
  a_immediate_launch: assert property (p_immediate_launch)
    else $error("command write did not launch");

  // No-op command write never launches
  property p_noop_silent;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_LINE_COMMAND && i_reg_wdata[30:27] == 4'hf)
      |=> !o_launch.valid;
  endproperty
  a_noop_silent: assert property (p_noop_silent)
    else $error("no-op command launched");

  // Trigger write relaunches stored command
  property p_trigger_launch;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_BLIT_TARGET_POS && state_q.sets[0].command[0])
      |=> (o_launch.valid && o_launch.command == $past(state_q.sets[0].command));
  endproperty
  a_trigger_launch: assert property (p_trigger_launch)
    else $error("trigger write did not relaunch");

  // Trigger write without auto mode does nothing
  property p_trigger_idle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_LINE_COUNT && !state_q.sets[1].command[0])
      |=> !o_launch.valid;
  endproperty
  a_trigger_idle: assert property (p_trigger_idle)
    else $error("launch without auto mode");

  // Command persists across trigger writes
  property p_command_persist;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_POLY_COUNT)
      |=> $stable(state_q.sets[2].command);
  endproperty
  a_command_persist: assert property (p_command_persist)
    else $error("command lost on trigger");

  // Pitch alignment and reserved bits read zero
  property p_pitch_zero;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_reg_read && i_reg_addr == OFS_BLIT_PITCH |=> (o_reg_rdata & ~MASK_PITCH) == 32'h0;
  endproperty
  a_pitch_zero: assert property (p_pitch_zero)
    else $error("pitch reserved bits set");

  // Write then read of the polygon foreground returns masked data
  property p_write_read;
    logic [31:0] v;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_write && i_reg_addr == OFS_POLY_PAT_FORE, v = i_reg_wdata)
      ##1 (i_reg_read && i_reg_addr == OFS_POLY_PAT_FORE)
      |=> o_reg_rdata == (v & MASK_COLOR);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("color readback mismatch");

  // Unmapped reads answer zero
  property p_unmapped_zero;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_reg_read && decode(i_reg_addr) == 5'h18) |=> o_reg_rdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // Line draws take the foreground color
  property p_line_fore;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_pixel_query.set == 2'h1 && state_q.sets[1].command[30:27] == 4'h3
       && state_q.sets[1].command[4:2] == 3'h2)
      |=> o_pixel_answer.pattern_color == $past(state_q.sets[1].pat_fore[23:0]);
  endproperty
  a_line_fore: assert property (p_line_fore)
    else $error("line pattern color wrong");

endmodule // blit_param_registers_2d

// ---- blit_param_registers_2d_tb_top.sv ----
// Purpose: Self-checking bench for the 2D parameter register set
// Assumes: Registers clear to zero on reset, every answer one cycle late
// Notes:   Random data from a fixed seed, corner cases written by hand
`timescale 1ns/1ns
`define CHK(g, e) check(32'(g), 32'(e))

module blit_param_registers_2d_tb_top;
  import blit_param_pkg::*;

  logic          i_core_clk = 1'b0;  // 125 MHz engine clock
  logic          i_sys_rst  = 1'b1;  // Held high from time zero
  logic [15:0]   i_reg_addr = 16'h0000;
  logic [31:0]   i_reg_wdata = 32'h0000_0000;
  logic          i_reg_write = 1'b0;
  logic          i_reg_read  = 1'b0;
  logic [31:0]   o_reg_rdata;
  launch_t       o_launch;
  logic          o_clip_enable;
  pixel_query_t  i_pixel_query = '0;
  pixel_answer_t o_pixel_answer;
  int            seed = 59;          // Fixed so runs repeat
  int            n_mismatch = 0;
  int            total_checks = 0;
  logic [31:0]   shadow [16];        // Values last written, unmasked
  logic [31:0]   rv;                 // Read-back scratch
  logic [31:0]   cmd;                // Command under test
  launch_t       lq;                 // Launch seen after each write
  logic [1:0]    s;
  logic [2:0]    r;
  logic [2:0]    c;
  // Register table in index order, with its writable masks
  logic [15:0]   ra [16] = '{OFS_BLIT_PITCH, OFS_BLIT_PAT_LOW, OFS_BLIT_PAT_HIGH,
    OFS_BLIT_PAT_BACK, OFS_BLIT_PAT_FORE, OFS_BLIT_SRC_FORE, OFS_BLIT_COMMAND,
    OFS_LINE_PITCH, OFS_LINE_PAT_FORE, OFS_LINE_COMMAND, OFS_POLY_PITCH,
    OFS_POLY_PAT_LOW, OFS_POLY_PAT_HIGH, OFS_POLY_PAT_BACK, OFS_POLY_PAT_FORE,
    OFS_POLY_COMMAND};
  // Pattern words keep all 32 bits, colors only their three low bytes
  logic [31:0]   rm [16] = '{MASK_PITCH, 32'hffff_ffff, 32'hffff_ffff, MASK_COLOR,
    MASK_COLOR, MASK_COLOR, MASK_COMMAND, MASK_PITCH, MASK_COLOR, MASK_COMMAND,
    MASK_PITCH, 32'hffff_ffff, 32'hffff_ffff, MASK_COLOR, MASK_COLOR, MASK_COMMAND};
  logic [15:0]   cmd_ofs [3] = '{OFS_BLIT_COMMAND, OFS_LINE_COMMAND, OFS_POLY_COMMAND};
  logic [15:0]   trig_ofs [3] = '{OFS_BLIT_TARGET_POS, OFS_LINE_COUNT, OFS_POLY_COUNT};
  logic [3:0]    ops [4] = '{OP_BLIT, OP_RECT, OP_LINE, OP_POLY};

  blit_param_registers_2d i_blit_param_registers_2d (
    .i_core_clk     (i_core_clk),
    .i_sys_rst      (i_sys_rst),
    .i_reg_addr     (i_reg_addr),
    .i_reg_wdata    (i_reg_wdata),
    .i_reg_write    (i_reg_write),
    .i_reg_read     (i_reg_read),
    .o_reg_rdata    (o_reg_rdata),
    .o_launch       (o_launch),
    .o_clip_enable  (o_clip_enable),
    .i_pixel_query  (i_pixel_query),
    .o_pixel_answer (o_pixel_answer)
  );

  // Clock, 8 ns period
  always #4 i_core_clk = ~i_core_clk;

  // Compare and count
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Verdict, the only exit of the run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle write; launch is captured in the cycle after
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_core_clk);
    i_reg_write <= 1'b0;
    #1 lq = o_launch;
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_core_clk);
    i_reg_read <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // Pixel query applied and left in place until the next call, answer looked at after the next edge
  task automatic pix(input logic [1:0] qs, input logic [2:0] qr, input logic [2:0] qc,
                     input logic [23:0] p, input logic b);
    @(posedge i_core_clk);
    i_pixel_query <= '{set: qs, row: qr, col: qc, pixel: p, image_bit: b};
    @(posedge i_core_clk);
    #1;
  endtask

  // Expected mono pattern color; left pixel sits at the byte's top bit
  function automatic logic [23:0] pat_exp(input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] fg, input logic [31:0] bg, input logic [2:0] qr,
      input logic [2:0] qc);
    logic [63:0] p;
    p = {hi, lo};
    return p[{qr, ~qc}] ? fg[23:0] : bg[23:0];
  endfunction

  // Command word from its fields, reserved bits cleared
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [2:0] dep,
                                     input logic [9:0] low_bits);
    return ({1'b0, op, 27'h0} | {27'h0, dep, 2'h0} | {22'h0, low_bits}) & MASK_COMMAND;
  endfunction

  // Watchdog; the whole sequence needs well under 20k cycles
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(OFS_BLIT_COMMAND, rv);
    `CHK(rv, RESET_VALUE);
    // Random fill of every register, two rounds, masked read-back
    repeat (2) begin
      for (int k = 0; k < 16; k++) begin
        shadow[k] = $random(seed);
        if (rm[k] == MASK_COMMAND) shadow[k][0] = 1'b1;  // Armed, so no launch
        wr(ra[k], shadow[k]);
        `CHK(lq.valid, 1'b0);
      end
      for (int k = 0; k < 16; k++) begin
        rd(ra[k], rv);
        `CHK(rv, shadow[k] & rm[k]);
      end
    end
    // Unmapped and trigger places read zero and keep nothing
    wr(16'ha4f8, 32'hffff_ffff);
    rd(16'ha4f8, rv);
    `CHK(rv, 32'h0);
    rd(OFS_BLIT_TARGET_POS, rv);
    `CHK(rv, 32'h0);
    rd(OFS_BLIT_SRC_FORE, rv);
    `CHK(rv, shadow[5] & MASK_COLOR);
    // Write then read with no gap, read sees the fresh value
    shadow[14] = $random(seed);
    @(posedge i_core_clk);
    i_reg_addr  <= OFS_POLY_PAT_FORE;
    i_reg_wdata <= shadow[14];
    i_reg_write <= 1'b1;
    @(posedge i_core_clk);
    i_reg_write <= 1'b0;
    i_reg_read  <= 1'b1;
    @(posedge i_core_clk);
    i_reg_read  <= 1'b0;
    #1 rv = o_reg_rdata;
    `CHK(rv, shadow[14] & MASK_COLOR);
    // Immediate launches, BLIT, RECT, LINE and POLY on every set, clip bit varied
    for (int i = 0; i < 12; i++) begin
      cmd = mk(ops[i % 4], 3'(i % 3), 10'($random(seed))) & 32'hffff_fffe;
      wr(cmd_ofs[i % 3], cmd);
      `CHK(lq.valid, 1'b1);
      `CHK(lq.set, i % 3);
      `CHK(lq.command, cmd);
      `CHK(o_clip_enable, cmd[CMD_CLIP_BIT]);
    end
    // Armed launches repeat without a rewrite; no-op disarms silently
    for (int i = 0; i < 3; i++) begin
      cmd = mk(ops[i + 1], DEPTH_16, 10'h103);
      wr(cmd_ofs[i], cmd);
      `CHK(lq.valid, 1'b0);
      repeat (2) begin
        wr(trig_ofs[i], $random(seed));
        `CHK(lq.valid, 1'b1);
        `CHK(lq.command, cmd);
      end
      wr(cmd_ofs[i], mk(OP_NOOP, DEPTH_8, 10'h0));
      `CHK(lq.valid, 1'b0);
      wr(trig_ofs[i], $random(seed));
      `CHK(lq.valid, 1'b0);
    end
    // Mono pattern on the blit set, polygon fill forces the foreground
    wr(OFS_BLIT_COMMAND, mk(OP_BLIT, DEPTH_24, 10'h101));
    wr(OFS_POLY_COMMAND, mk(OP_POLY, DEPTH_24, 10'h001));
    for (int i = 0; i < 48; i++) begin
      s = (i % 3 == 1) ? 2'd2 : 2'(3 * (i % 2));
      r = (i == 0) ? 3'd0 : 3'($random(seed));
      c = (i == 0) ? 3'd0 : 3'($random(seed));
      pix(s, r, c, 24'h0, 1'b0);
      if (s == 2'd2) begin
        `CHK(o_pixel_answer.pattern_color, shadow[14][23:0]);
      end else begin
        `CHK(o_pixel_answer.pattern_color, pat_exp(shadow[1], shadow[2], shadow[4], shadow[3], r, c));
      end
    end
    // Color pattern selected: no mono color
    wr(OFS_BLIT_COMMAND, mk(OP_BLIT, DEPTH_24, 10'h001));
    pix(2'd0, 3'd3, 3'd5, 24'h0, 1'b1);
    `CHK(o_pixel_answer.pattern_color, 24'h0);
    // Line set always draws its foreground, cut to the target depth
    for (int d = 0; d < 3; d++) begin
      wr(OFS_LINE_COMMAND, mk(OP_LINE, 3'(d), 10'h000));
      pix(2'd1, 3'($random(seed)), 3'($random(seed)), 24'h0, 1'b0);
      rv = shadow[8] & ((d == 0) ? 32'h0000_00ff : (d == 1) ? 32'h0000_ffff : MASK_COLOR);
      `CHK(o_pixel_answer.pattern_color, rv[23:0]);
    end
    // Mono source, transparent then opaque
    for (int t = 0; t < 2; t++) begin
      wr(OFS_BLIT_COMMAND, mk(OP_BLIT, DEPTH_24, t ? 10'h0c1 : 10'h2c1));
      for (int b = 0; b < 2; b++) begin
        pix(2'd0, 3'd0, 3'd0, 24'h0, 1'(b));
        `CHK(o_pixel_answer.source_color, shadow[5][23:0]);
        `CHK(o_pixel_answer.write_enable, (b == 1) || (t == 1));
      end
    end
    // Color transfer with transparency at each depth
    for (int d = 0; d < 3; d++) begin
      // At 8 bits the palette index sits in both low bytes of the key
      if (d == 0) begin
        shadow[5][15:8] = shadow[5][7:0];
        wr(OFS_BLIT_SRC_FORE, shadow[5]);
      end
      wr(OFS_BLIT_COMMAND, mk(OP_BLIT, 3'(d), 10'h281));
      rv = (d == 0) ? {24'h0, shadow[5][7:0]} : (d == 1) ? {16'h0, shadow[5][15:0]} : shadow[5];
      pix(2'd0, 3'd0, 3'd0, rv[23:0], 1'b0);
      `CHK(o_pixel_answer.write_enable, d == 2);
      `CHK(o_pixel_answer.source_color, rv[23:0]);
      pix(2'd0, 3'd0, 3'd0, rv[23:0] ^ 24'h000001, 1'b0);
      `CHK(o_pixel_answer.write_enable, 1'b1);
    end
    tally_and_finish();
  end

endmodule // blit_param_registers_2d_tb_top
